// >>> common/sep_pkg.sv
// Package of constants and types for the serial EEPROM command port
package sep_pkg;

    // ------------------------------------------------------------
    // Array and frame geometry
    // ------------------------------------------------------------
    localparam int   SEP_ADDR_W      = 8;
    localparam int   SEP_DATA_W      = 8;
    localparam int   SEP_DEPTH       = 256;
    localparam int   SEP_AW_SMALL    = 7;
    localparam int   SEP_AW_LARGE    = 9;
    localparam int   SEP_FIFO_DEPTH  = 16;

    // ------------------------------------------------------------
    // Opcodes and special subcodes
    // ------------------------------------------------------------
    localparam logic [1:0] SEP_OP_READ   = 2'h2;
    localparam logic [1:0] SEP_OP_ERASE  = 2'h3;
    localparam logic [1:0] SEP_OP_WRITE  = 2'h1;
    localparam logic [1:0] SEP_OP_SPEC   = 2'h0;
    localparam logic [1:0] SEP_SUB_UNLK  = 2'h3;
    localparam logic [1:0] SEP_SUB_LOCK  = 2'h0;
    localparam logic [1:0] SEP_SUB_ERASE_WHOLE_ARRAY_CMD  = 2'h2;
    localparam logic [1:0] SEP_SUB_FILL  = 2'h1;

    // ------------------------------------------------------------
    // Timing: internal write cycle per location
    // ------------------------------------------------------------
    localparam int   SEP_CLK_MHZ     = 200;
    localparam int   SEP_WR_NS       = 100;
    localparam int   SEP_WR_CYC      = (SEP_WR_NS * SEP_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SEP_ERASED = 8'hff;
    localparam logic [7:0] SEP_MEM_RST = 8'hff;

    typedef enum logic [2:0] {
        SEP_ST_IDLE  = 3'b000,
        SEP_ST_OPC   = 3'b001,
        SEP_ST_ADDR  = 3'b010,
        SEP_ST_DATA  = 3'b011,
        SEP_ST_RDOUT = 3'b100,
        SEP_ST_DONE  = 3'b101
    } sep_state_e;

    // One programming job handed to the write engine
    typedef struct packed {
        logic       all;
        logic [7:0] addr;
        logic [7:0] data;
    } sep_job_s;

endpackage : sep_pkg

// >>> rtl/sep_fifo.sv
// Parameterised valid/ready FIFO for programming jobs
`timescale 1ns/1ps
module sep_fifo
    import sep_pkg::*;
#(
    parameter int W = 17,
    parameter int D = 16
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [PW:0]  wp_q;
    logic [PW:0]  rp_q;
    logic [PW:0]  wp_d;
    logic [PW:0]  rp_d;

    assign in_ready  = (wp_q - rp_q) != (PW+1)'(D);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem[rp_q[PW-1:0]];

    always_comb
    begin
        wp_d = wp_q + (PW+1)'(in_valid & in_ready);
        rp_d = rp_q + (PW+1)'(out_valid & out_ready);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
            mem[wp_q[PW-1:0]] <= in_data;
    end
endmodule : sep_fifo

// >>> rtl/sep_port.sv
// Serial EEPROM command port: frame decoder, array and self-timed write engine
`timescale 1ns/1ps
module sep_port
    import sep_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic large_array,
    input  wire logic chip_select,
    input  wire logic serial_clock,
    input  wire logic serial_data_in,
    output logic      data_out_o,
    output logic      data_out_oe_n,
    output logic      busy
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sk_s_q;
    logic [1:0] di_s_q;
    logic       cs_q;
    logic       sk_q;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_s_q <= '0;
            sk_s_q <= '0;
            di_s_q <= '0;
            cs_q   <= 1'b0;
            sk_q   <= 1'b0;
        end
        else
        begin
            cs_s_q <= {cs_s_q[0], chip_select};
            sk_s_q <= {sk_s_q[0], serial_clock};
            di_s_q <= {di_s_q[0], serial_data_in};
            cs_q   <= cs_s_q[1];
            sk_q   <= sk_s_q[1];
        end
    end

    logic cs;
    logic di;
    logic sk_rise;
    logic cs_fall;
    assign cs      = cs_s_q[1];
    assign di      = di_s_q[1];
    assign sk_rise = cs && sk_s_q[1] && !sk_q;
    assign cs_fall = cs_q && !cs;

    // ------------------------------------------------------------
    // Frame decoder
    // ------------------------------------------------------------
    sep_state_e st_q;
    sep_state_e st_d;
    logic [1:0] op_q;
    logic [1:0] op_d;
    logic [8:0] sh_q;
    logic [8:0] sh_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic       arm_q;
    logic       arm_d;
    logic       armall_q;
    logic       armall_d;
    logic       unlk_q;
    logic       unlk_d;
    logic [7:0] wdat_q;
    logic [7:0] wdat_d;
    logic       dq_q;
    logic       dq_d;
    logic       oen_q;
    logic       oen_d;
    logic [7:0] rd_byte;
    logic       eng_busy;
    logic [3:0] aw;

    assign aw = large_array ? 4'(SEP_AW_LARGE) : 4'(SEP_AW_SMALL);

    function automatic logic [7:0] addr_of(input logic [8:0] s, input logic lg);
        addr_of = lg ? s[7:0] : {1'b0, s[6:0]};
    endfunction : addr_of

    always_comb
    begin
        st_d     = st_q;
        op_d     = op_q;
        sh_d     = sh_q;
        cnt_d    = cnt_q;
        addr_d   = addr_q;
        arm_d    = arm_q;
        armall_d = armall_q;
        unlk_d   = unlk_q;
        wdat_d   = wdat_q;
        dq_d     = dq_q;
        oen_d    = oen_q;
        if (!cs)
        begin
            st_d  = SEP_ST_IDLE;
            cnt_d = '0;
            oen_d = 1'b1;
            if (!cs_fall)
            begin
                arm_d    = 1'b0;
                armall_d = 1'b0;
            end
        end
        // busy rejects; reports status, low then high
        else if (eng_busy || (st_q == SEP_ST_IDLE && arm_q))
        begin
            st_d  = SEP_ST_DONE;
            dq_d  = 1'b0;
            oen_d = 1'b0;
        end
        else if (st_q == SEP_ST_DONE)
        begin
            // ready shown high until select drops
            dq_d = 1'b1;
        end
        else if (sk_rise)
        begin
            unique case (st_q)
                SEP_ST_IDLE:
                    if (di)
                    begin
                        st_d  = SEP_ST_OPC;
                        cnt_d = '0;
                    end
                SEP_ST_OPC:
                begin
                    op_d = {op_q[0], di};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == 4'h1)
                    begin
                        st_d  = SEP_ST_ADDR;
                        cnt_d = '0;
                    end
                end
                SEP_ST_ADDR:
                begin
                    sh_d  = {sh_q[7:0], di};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == aw - 4'h1)
                    begin
                        cnt_d  = '0;
                        addr_d = addr_of({sh_q[7:0], di}, large_array);
                        st_d   = SEP_ST_DONE;
                        unique case (op_q)
                            // dummy 0 first; no lock check
                            SEP_OP_READ:
                            begin
                                st_d  = SEP_ST_RDOUT;
                                dq_d  = 1'b0;
                                oen_d = 1'b0;
                            end
                            SEP_OP_ERASE:
                            begin
                                arm_d  = unlk_q;
                                wdat_d = SEP_ERASED;
                            end
                            SEP_OP_WRITE:
                                st_d = SEP_ST_DATA;
                            SEP_OP_SPEC:
                            begin
                                unique case (large_array ? sh_q[7:6] : sh_q[5:4])
                                    SEP_SUB_UNLK: unlk_d = 1'b1;
                                    SEP_SUB_LOCK: unlk_d = 1'b0;
                                    SEP_SUB_ERASE_WHOLE_ARRAY_CMD:
                                    begin
                                        arm_d    = unlk_q;
                                        armall_d = 1'b1;
                                        wdat_d   = SEP_ERASED;
                                    end
                                    SEP_SUB_FILL:
                                    begin
                                        armall_d = 1'b1;
                                        st_d     = SEP_ST_DATA;
                                    end
                                endcase
                            end
                        endcase
                    end
                end
                SEP_ST_DATA:
                begin
                    // eight data bits; likewise for fill
                    wdat_d = {wdat_q[6:0], di};
                    cnt_d  = cnt_q + 4'h1;
                    if (cnt_q == 4'h7)
                    begin
                        arm_d = unlk_q;
                        st_d  = SEP_ST_DONE;
                    end
                end
                SEP_ST_RDOUT:
                begin
                    dq_d  = rd_byte[3'(4'h7 - cnt_q)];
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == 4'h7)
                    begin
                        cnt_d  = '0;
                        addr_d = large_array ? addr_q + 8'h1 : {1'b0, 7'(addr_q[6:0] + 7'h1)};
                    end
                end
                default:
                    st_d = SEP_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q     <= SEP_ST_IDLE;
            op_q     <= '0;
            sh_q     <= '0;
            cnt_q    <= '0;
            addr_q   <= '0;
            arm_q    <= 1'b0;
            armall_q <= 1'b0;
            unlk_q   <= 1'b0;
            wdat_q   <= '0;
            dq_q     <= 1'b0;
            oen_q    <= 1'b1;
        end
        else
        begin
            st_q     <= st_d;
            op_q     <= op_d;
            sh_q     <= sh_d;
            cnt_q    <= cnt_d;
            addr_q   <= addr_d;
            arm_q    <= arm_d;
            armall_q <= armall_d;
            unlk_q   <= unlk_d;
            wdat_q   <= wdat_d;
            dq_q     <= dq_d;
            oen_q    <= oen_d;
        end
    end

    // driven only in read or status
    assign data_out_o    = dq_q;
    assign data_out_oe_n = oen_q;

    // ------------------------------------------------------------
    // Job queue and self-timed write engine
    // ------------------------------------------------------------
    // Jobs are queued so a fill-all sequence can stall cleanly on back-pressure
    sep_job_s   job_in;
    sep_job_s   job_out;
    logic       job_valid;
    logic       job_ready;
    logic       job_take;
    logic       fifo_ready;
    logic [7:0] mem [SEP_DEPTH];
    logic [7:0] wa_q;
    logic [7:0] wa_d;
    logic [7:0] tmr_q;
    logic [7:0] tmr_d;
    logic       run_q;
    logic       run_d;
    logic       bsy_q;

    assign job_in   = '{all: armall_q, addr: addr_q, data: wdat_q};
    assign job_take = cs_fall && arm_q;
    // Pop only as the job finishes, so its fields stay valid for the whole cycle
    assign job_ready = run_q && !run_d;
    assign eng_busy = run_q || job_valid;
    assign rd_byte  = mem[addr_q];

    sep_fifo #(.W($bits(sep_job_s)), .D(SEP_FIFO_DEPTH)) u_fifo (
        .clk       (mclk),
        .rst       (sys_rst),
        .in_data   (job_in),
        .in_valid  (job_take),
        .in_ready  (fifo_ready),
        .out_data  (job_out),
        .out_valid (job_valid),
        .out_ready (job_ready)
    );

    always_comb
    begin
        run_d = run_q;
        wa_d  = wa_q;
        tmr_d = tmr_q;
        if (!run_q && job_valid)
        begin
            run_d = 1'b1;
            wa_d  = job_out.all ? 8'h0 : job_out.addr;
            tmr_d = 8'(SEP_WR_CYC);
        end
        else if (run_q)
        begin
            tmr_d = tmr_q - 8'h1;
            if (tmr_q == 8'h1)
            begin
                tmr_d = 8'(SEP_WR_CYC);
                wa_d  = wa_q + 8'h1;
                if (!job_out.all || wa_q == 8'(SEP_DEPTH - 1) || (!large_array && wa_q == 8'h7f))
                    run_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            run_q <= 1'b0;
            wa_q  <= '0;
            tmr_q <= '0;
            bsy_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            wa_q  <= wa_d;
            tmr_q <= tmr_d;
            bsy_q <= run_d || job_valid || !fifo_ready;
        end
    end

    // program byte at each location; writes the job data, ones for erase
    always_ff @(posedge mclk)
    begin
        if (run_q && tmr_q == 8'h1)
            mem[wa_q] <= job_out.data;
    end

    assign busy = bsy_q;
endmodule : sep_port

// >>> tb/sep_port_assertions.sv
// Concurrent checks on the command port pins
`timescale 1ns/1ps
module sep_port_assertions
    import sep_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic large_array,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic data_out_o,
    input wire logic data_out_oe_n,
    input wire logic busy
);
    // ------------------------------
    // Busy length counter
    // ------------------------------
    // Generous bound: a whole-array cycle plus slack for queued jobs
    localparam int BUSY_MAX = 2 * SEP_DEPTH * SEP_WR_CYC;
    logic [15:0] bcnt_q;
    logic [15:0] bcnt_d;
    always_comb bcnt_d = busy ? bcnt_q + 16'h1 : 16'h0;
    always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
            bcnt_q <= 16'h0;
        else
            bcnt_q <= bcnt_d;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_quiet;
        (!serial_clock && !busy && !data_out_oe_n) [*7];
    endsequence
    sequence s_end;
        $fell(busy) ##0 (chip_select && !data_out_oe_n);
    endsequence
    a_oe_idle_off: assert property (
        !chip_select [*6] |-> data_out_oe_n) else $error("data out driven while deselected");
    a_oe_needs_cs: assert property (
        $fell(data_out_oe_n) |-> chip_select) else $error("data out driven without select");
    a_busy_on_fall: assert property (
        $rose(busy) |-> !chip_select) else $error("cycle started while selected");
    a_busy_min_len: assert property (
        $rose(busy) |=> busy [*8]) else $error("cycle ended too early");
    a_busy_max_len: assert property (
        bcnt_q < BUSY_MAX) else $error("cycle never ends");
    a_busy_low_out: assert property (
        (busy && !data_out_oe_n) [*3] |-> !data_out_o) else $error("busy not reported low");
    a_ready_high_out: assert property (
        s_end |-> ##[0:4] data_out_o) else $error("ready not reported high");
    a_dout_hold_low: assert property (
        s_quiet |-> $stable(data_out_o)) else $error("data out moved without clock rise");
endmodule : sep_port_assertions
bind sep_port sep_port_assertions u_chk (.mclk, .sys_rst, .large_array, .chip_select,
    .serial_clock, .serial_data_in, .data_out_o, .data_out_oe_n, .busy);

// >>> tb/sep_host.sv
// Host model driving the link pins bit by bit
`timescale 1ns/1ps
module sep_host
    import sep_pkg::*;
(
    input  wire logic mclk,
    input  wire logic large_array,
    output logic      chip_select,
    output logic      serial_clock,
    output logic      serial_data_in,
    input  wire logic data_out_o,
    input  wire logic data_out_oe_n
);
    logic dout_q;
    logic drv_q;
    logic ok_q;
    int   low_cnt;
    logic pin_do;
    // Released pin has no pull, so a stray sample reads the inverse
    assign pin_do = data_out_oe_n ? ~data_out_o : data_out_o;
    initial
    begin
        chip_select = 1'h0;
        serial_clock = 1'h0;
        serial_data_in = 1'h0;
    end
    // ------------------------------
    // Link tasks
    // ------------------------------
    // data set half a period before the rise
    task automatic pulse(input logic b);
        serial_data_in = b;
        #32;
        serial_clock = 1'h1;
        #32;
        dout_q = pin_do;
        drv_q = ~data_out_oe_n;
        serial_clock = 1'h0;
    endtask : pulse
    task automatic send(input logic [8:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            pulse(v[i]);
    endtask : send
    // start bit, opcode, address MSB first
    task automatic cmd(input logic [1:0] op, input logic [8:0] a);
        @(posedge mclk);
        #1;
        chip_select = 1'h1;
        #32;
        send({6'h0, 1'h1, op}, 3);
        send(a, large_array ? 9 : 7);
    endtask : cmd
    // data in carries nothing once deselected
    task automatic done();
        chip_select = 1'h0;
        serial_data_in = ~serial_data_in;
        #64;
    endtask : done
    // raise select and wait for ready, bounded
    task automatic poll();
        chip_select = 1'h1;
        low_cnt = 0;
        ok_q = 1'h0;
        for (int i = 0; i < 20000 && !ok_q; i++)
        begin
            @(posedge mclk);
            #1;
            ok_q = !data_out_oe_n && pin_do;
            low_cnt += int'(!data_out_oe_n && !pin_do);
        end
        done();
    endtask : poll
endmodule : sep_host

// >>> tb/sep_port_tb.sv
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
module sep_port_tb
    import sep_pkg::*;
;
    logic mclk;
    logic sys_rst;
    logic large_array;
    logic chip_select;
    logic serial_clock;
    logic serial_data_in;
    logic data_out_o;
    logic data_out_oe_n;
    logic busy;
    int   failures;
    int   tests_run;

    sep_port DUT (.mclk, .sys_rst, .large_array, .chip_select, .serial_clock,
        .serial_data_in, .data_out_o, .data_out_oe_n, .busy);
    sep_host host (.mclk, .large_array, .chip_select, .serial_clock,
        .serial_data_in, .data_out_o, .data_out_oe_n);

    initial
    begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic reset(input logic l);
        @(posedge mclk);
        #1 sys_rst = 1'h1;
        large_array = l;
        repeat (10) @(posedge mclk);
        #1 sys_rst = 1'h0;
    endtask : reset
    // Dummy address bit is sent as 1 on purpose
    function automatic logic [8:0] ad(input logic [7:0] a);
        return large_array ? {1'h1, a} : {2'h0, a[6:0]};
    endfunction : ad
    function automatic logic [8:0] sp(input logic [1:0] s);
        return large_array ? {s, 7'h55} : {2'h0, s, 5'h15};
    endfunction : sp
    task automatic spc(input logic [1:0] s);
        host.cmd(SEP_OP_SPEC, sp(s));
        host.done();
    endtask : spc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.cmd(SEP_OP_WRITE, ad(a));
        host.send({1'h0, d}, 8);
    endtask : wr
    task automatic fin(input logic exp);
        host.done();
        check({7'h0, busy}, {7'h0, exp}, "cycle start");
        if (exp)
        begin
            host.poll();
            check({7'h0, host.ok_q}, 8'h01, "ready");
            if (host.ok_q !== 1'h1)
                stop_test();
        end
    endtask : fin
    task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] b;
        host.cmd(SEP_OP_READ, ad(a));
        check({6'h0, host.drv_q, host.dout_q}, 8'h02, "dummy bit");
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                host.pulse(1'h0);
                b[i] = host.dout_q;
            end
            check(b, k ? e1 : e0, "read byte");
        end
        host.done();
    endtask : rd
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial
    begin
        failures = 0;
        tests_run = 0;
        sys_rst = 1'h1;
        large_array = 1'h1;
        reset(1'h1);
        check({6'h0, data_out_oe_n, busy}, 8'h02, "after reset");
        spc(SEP_SUB_UNLK);
        wr(8'h7f, 8'h55);
        fin(1'h1);
        spc(SEP_SUB_LOCK);
        wr(8'h20, 8'h3c);
        fin(1'h0);
        spc(SEP_SUB_UNLK);
        host.cmd(SEP_OP_SPEC, sp(SEP_SUB_FILL));
        host.send({1'h0, 8'h3c}, 8);
        fin(1'h1);
        wr(8'hff, 8'h81);
        fin(1'h1);
        wr(8'h00, 8'h42);
        fin(1'h1);
        rd(8'hfe, 8'h3c, 8'h81);
        rd(8'hff, 8'h81, 8'h42);
        host.cmd(SEP_OP_ERASE, ad(8'h00));
        fin(1'h1);
        rd(8'hff, 8'h81, 8'hff);
        spc(SEP_SUB_ERASE_WHOLE_ARRAY_CMD);
        check({7'h0, busy}, 8'h01, "whole erase");
        wr(8'h05, 8'h11);
        fin(1'h1);
        check({7'h0, host.low_cnt > 0}, 8'h01, "busy shown");
        rd(8'h05, 8'hff, 8'hff);
        spc(SEP_SUB_LOCK);
        wr(8'h05, 8'h11);
        fin(1'h0);
        rd(8'h04, 8'hff, 8'hff);
        reset(1'h0);
        spc(SEP_SUB_UNLK);
        wr(8'h7f, 8'h55);
        fin(1'h1);
        wr(8'h00, 8'ha5);
        fin(1'h1);
        rd(8'h7f, 8'h55, 8'ha5);
        stop_test();
    end
endmodule : sep_port_tb
